// ---- common/isf_defines.vh ----
`ifndef ISF_DEFINES_VH
`define ISF_DEFINES_VH

// Register byte offsets inside the controller window
`define ISF_OFS_DATA_CMD      8'h10
`define ISF_OFS_INTR_STAT     8'h2C
`define ISF_OFS_INTR_MASK     8'h30
`define ISF_OFS_RAW_STAT      8'h34
`define ISF_OFS_TX_TL         8'h3C
`define ISF_OFS_CLR_INTR      8'h40
`define ISF_OFS_CLR_TX_OVER   8'h4C
`define ISF_OFS_CLR_RD_REQ    8'h50
`define ISF_OFS_CLR_TX_ABRT   8'h54
`define ISF_OFS_CLR_RX_DONE   8'h58
`define ISF_OFS_CLR_ACTIVITY  8'h5C
`define ISF_OFS_CLR_STOP      8'h60
`define ISF_OFS_CLR_START     8'h64
`define ISF_OFS_ENABLE        8'h6C
`define ISF_OFS_TX_LEVEL      8'h74
`define ISF_OFS_ABRT_CAUSE    8'h80

// Status bit positions
`define ISF_BIT_START         10
`define ISF_BIT_STOP          9
`define ISF_BIT_ACTIVITY      8
`define ISF_BIT_RX_DONE       7
`define ISF_BIT_TX_ABRT       6
`define ISF_BIT_RD_REQ        5
`define ISF_BIT_TX_EMPTY      4
`define ISF_BIT_TX_OVER       3
`define ISF_BIT_ENABLE        0

// Widths and reset values
`define ISF_STAT_W            12
`define ISF_MASK_RESET        12'h8FF
`define ISF_TL_RESET          8'h00
`define ISF_CAUSE_W           16

`endif

// ---- hw/isf_fifo_mem.v ----
`include "isf_defines.vh"

// Small synchronous RAM; read data is registered
module isf_fifo_mem #(
    parameter DW = 9,                  // Word width
    parameter AW = 5                   // Address width
) (
    input  wire          sys_clk,
    input  wire          ce,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire          rd_en,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);

    reg [DW-1:0] mem [0:(1<<AW)-1];    // Storage, no reset needed

    // Write port
    always @(posedge sys_clk) begin
        if (ce && wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read port, data lands one cycle after the request
    always @(posedge sys_clk) begin
        if (ce && rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule // isf_fifo_mem

// ---- hw/isf_status.v ----
`include "isf_defines.vh"

module isf_status #(
    parameter DW    = 9,               // Data plus command bit
    parameter AW    = 5,               // FIFO address width
    parameter DEPTH = 32,              // FIFO entries
    parameter TLW   = 8                // Threshold field width
) (
    input  wire                    sys_clk,
    input  wire                    rst_n,
    input  wire                    ce,
    // Register port
    input  wire                    psel,
    input  wire                    penable,
    input  wire                    pwrite,
    input  wire [7:0]              paddr,
    input  wire [31:0]             pwdata,
    output reg  [31:0]             prdata,
    output reg                     pready,
    output reg                     pslverr,
    // Events and levels from the controller core
    input  wire                    start_restart_evt,
    input  wire                    stop_condition_evt,
    input  wire                    core_active,
    input  wire                    slave_tx_nack_evt,
    input  wire                    abort_evt,
    input  wire [`ISF_CAUSE_W-1:0] abort_cause,
    input  wire                    read_request_evt,
    input  wire                    fsm_active,
    // Transmit FIFO drain side
    input  wire                    tx_pop,
    output reg                     tx_data_valid,
    output reg  [DW-1:0]           tx_data,
    output reg                     tx_not_empty,
    // Bus and processor facing outputs
    output reg                     scl_stretch,
    output reg                     internal_enable_signal,
    output reg                     irq
);

    // Register port decode
    wire        acc_phase;             // Access phase, first cycle only
    wire        wr_acc;                // Write taken this cycle
    wire        rd_acc;                // Read taken this cycle
    reg         addr_known;            // Offset is mapped
    reg  [31:0] next_prdata;           // Read mux result

    // Control registers
    reg                     controller_enable_reg;        // Software enable
    reg  [`ISF_STAT_W-1:0]  interrupt_mask_reg;           // One per status bit
    reg  [TLW-1:0]          transmit_threshold_reg;       // FIFO level threshold
    reg  [`ISF_CAUSE_W-1:0] abort_cause_reg;              // Why the last abort happened

    // Sticky flags; tx_empty_flag alone follows the level
    reg start_restart_seen;            // START or RESTART seen
    reg stop_condition_seen;           // STOP seen
    reg activity_flag;                 // Controller was busy
    reg rx_done_flag;                  // Slave transmit finished
    reg transmit_abort_flag;           // Transmit abort pending
    reg read_request_flag;             // Remote master wants data
    reg tx_over_flag;                  // Write to a full FIFO
    reg tx_empty_flag;                 // Level at or below threshold

    // FIFO bookkeeping
    reg  [AW-1:0] wr_ptr;              // Next slot to write
    reg  [AW-1:0] rd_ptr;              // Next slot to read
    reg  [AW:0]   tx_level;            // Entries held, 0 to DEPTH
    wire          flush;               // Hold FIFO empty
    wire          push_req;            // Write to data command port
    wire          push;                // Push accepted
    wire          pop;                 // Pop accepted
    wire          fifo_full;           // Level at DEPTH

    // Clear strobes, one cycle each
    wire clr_all, clr_start, clr_stop, clr_act;
    wire clr_done, clr_abrt, clr_rdreq, clr_over;

    wire [`ISF_STAT_W-1:0] raw_stat;   // Raw flag vector
    wire [`ISF_STAT_W-1:0] masked;     // Masked flag vector
    wire [DW-1:0]          mem_rdata;  // Registered RAM output

    // Matches an offset; used for the clear reads and the data command write
    function rd_hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            rd_hit = (addr == ofs);
        end
    endfunction

    // A single wait state: pready goes high on the second access cycle
    assign acc_phase = psel & penable & ~pready;
    assign wr_acc    = acc_phase & pwrite;
    assign rd_acc    = acc_phase & ~pwrite;

    // Reading a clear register is what clears; writes there do nothing
    assign clr_all   = rd_acc & rd_hit(paddr, `ISF_OFS_CLR_INTR);
    assign clr_start = clr_all | (rd_acc & rd_hit(paddr, `ISF_OFS_CLR_START));
    assign clr_stop  = clr_all | (rd_acc & rd_hit(paddr, `ISF_OFS_CLR_STOP));
    assign clr_act   = clr_all | (rd_acc & rd_hit(paddr, `ISF_OFS_CLR_ACTIVITY));
    assign clr_done  = clr_all | (rd_acc & rd_hit(paddr, `ISF_OFS_CLR_RX_DONE));
    assign clr_abrt  = clr_all | (rd_acc & rd_hit(paddr, `ISF_OFS_CLR_TX_ABRT));
    assign clr_rdreq = clr_all | (rd_acc & rd_hit(paddr, `ISF_OFS_CLR_RD_REQ));
    assign clr_over  = clr_all | (rd_acc & rd_hit(paddr, `ISF_OFS_CLR_TX_OVER));

    // FIFO control; an abort or a disable empties it and keeps it empty
    assign flush     = ~controller_enable_reg | transmit_abort_flag | abort_evt;
    assign fifo_full = (tx_level == DEPTH[AW:0]);
    assign push_req  = wr_acc & rd_hit(paddr, `ISF_OFS_DATA_CMD);
    assign push      = push_req & ~fifo_full & ~flush;
    assign pop       = tx_pop & (tx_level != {(AW+1){1'b0}}) & ~flush;

    // Raw flag vector, receive side bits are not held here
    assign raw_stat = {1'b0,
                       start_restart_seen,
                       stop_condition_seen,
                       activity_flag,
                       rx_done_flag,
                       transmit_abort_flag,
                       read_request_flag,
                       tx_empty_flag,
                       tx_over_flag,
                       3'b000};
    assign masked   = raw_stat & interrupt_mask_reg;

    // Read mux; unmapped offsets read zero with an error
    always @* begin
        addr_known  = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `ISF_OFS_INTR_STAT:  next_prdata[`ISF_STAT_W-1:0] = masked;
            `ISF_OFS_INTR_MASK:  next_prdata[`ISF_STAT_W-1:0] = interrupt_mask_reg;
            `ISF_OFS_RAW_STAT:   next_prdata[`ISF_STAT_W-1:0] = raw_stat;
            `ISF_OFS_TX_TL:      next_prdata[TLW-1:0] = transmit_threshold_reg;
            `ISF_OFS_ENABLE:     next_prdata[`ISF_BIT_ENABLE] = controller_enable_reg;
            `ISF_OFS_TX_LEVEL:   next_prdata[AW:0] = tx_level;
            `ISF_OFS_ABRT_CAUSE: next_prdata[`ISF_CAUSE_W-1:0] = abort_cause_reg;
            `ISF_OFS_CLR_INTR, `ISF_OFS_CLR_START, `ISF_OFS_CLR_STOP, `ISF_OFS_CLR_ACTIVITY,
            `ISF_OFS_CLR_RX_DONE, `ISF_OFS_CLR_TX_ABRT, `ISF_OFS_CLR_RD_REQ, `ISF_OFS_CLR_TX_OVER,
            `ISF_OFS_DATA_CMD:   next_prdata[0] = 1'b0;
            default:             addr_known = 1'b0;
        endcase
    end

    // Register port handshake and read data capture
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (ce) begin
            pready  <= acc_phase;
            pslverr <= acc_phase & ~addr_known;
            if (rd_acc) begin
                prdata <= next_prdata;
            end
        end
    end

    // Software written control registers
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            controller_enable_reg  <= 1'b0;
            interrupt_mask_reg     <= `ISF_MASK_RESET;
            transmit_threshold_reg <= `ISF_TL_RESET;
        end else if (ce && wr_acc) begin
            // Steers flushing, the tx level flag and the enable chain
            if (paddr == `ISF_OFS_ENABLE) begin
                controller_enable_reg <= pwdata[`ISF_BIT_ENABLE];
            end
            if (paddr == `ISF_OFS_INTR_MASK) begin
                interrupt_mask_reg <= pwdata[`ISF_STAT_W-1:0];
            end
            if (paddr == `ISF_OFS_TX_TL) begin
                transmit_threshold_reg <= pwdata[TLW-1:0];
            end
        end
    end

    // Internal enable lingers until the state machines finish after disable
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_enable_signal <= 1'b0;
        end else if (ce) begin
            internal_enable_signal <= controller_enable_reg | fsm_active;
        end
    end

    // Bus condition flags; a set in the same cycle as a clear wins
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_restart_seen  <= 1'b0;
            stop_condition_seen <= 1'b0;
        end else if (ce) begin
            if (start_restart_evt) begin
                start_restart_seen <= 1'b1;
            end else if (clr_start) begin
                start_restart_seen <= 1'b0;
            end
            if (stop_condition_evt) begin
                stop_condition_seen <= 1'b1;
            end else if (clr_stop) begin
                stop_condition_seen <= 1'b0;
            end
        end
    end

    // Sticky activity; stays set after the core falls idle
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            activity_flag <= 1'b0;
        end else if (ce) begin
            if (core_active) begin
                activity_flag <= 1'b1;
            end else if (clr_act || !controller_enable_reg) begin
                activity_flag <= 1'b0;
            end
        end
    end

    // Slave transmit done and read request
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_done_flag      <= 1'b0;
            read_request_flag <= 1'b0;
            scl_stretch       <= 1'b0;
        end else if (ce) begin
            if (slave_tx_nack_evt) begin
                rx_done_flag <= 1'b1;
            end else if (clr_done) begin
                rx_done_flag <= 1'b0;
            end
            // Stretch follows the request flag until serviced
            if (read_request_evt) begin
                read_request_flag <= 1'b1;
                scl_stretch       <= 1'b1;
            end else if (clr_rdreq) begin
                read_request_flag <= 1'b0;
                scl_stretch       <= 1'b0;
            end
        end
    end

    // Transmit abort and its cause
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_abort_flag <= 1'b0;
            abort_cause_reg     <= {`ISF_CAUSE_W{1'b0}};
        end else if (ce) begin
            if (abort_evt) begin
                transmit_abort_flag <= 1'b1;
                abort_cause_reg     <= abort_cause;
            end else if (clr_abrt) begin
                // Releases the flush, new bytes accepted from next cycle
                transmit_abort_flag <= 1'b0;
                abort_cause_reg     <= {`ISF_CAUSE_W{1'b0}};
            end
        end
    end

    // Overflow and threshold flags
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_over_flag  <= 1'b0;
            tx_empty_flag <= 1'b0;
        end else if (ce) begin
            if (push_req && fifo_full) begin
                tx_over_flag <= 1'b1;
            end else if (clr_over || !internal_enable_signal) begin
                tx_over_flag <= 1'b0;
            end
            // Flushed FIFO shows level 0, so this tracks activity when disabled
            tx_empty_flag <= internal_enable_signal &
                             ({{(TLW-AW-1){1'b0}}, tx_level} <= transmit_threshold_reg);
        end
    end

    // FIFO pointers and level
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr   <= {AW{1'b0}};
            rd_ptr   <= {AW{1'b0}};
            tx_level <= {(AW+1){1'b0}};
        end else if (ce) begin
            if (flush) begin
                wr_ptr   <= {AW{1'b0}};
                rd_ptr   <= {AW{1'b0}};
                tx_level <= {(AW+1){1'b0}};
            end else begin
                if (push) begin
                    wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
                end
                if (pop) begin
                    rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
                end
                if (push && !pop) begin
                    tx_level <= tx_level + {{AW{1'b0}}, 1'b1};
                end else if (pop && !push) begin
                    tx_level <= tx_level - {{AW{1'b0}}, 1'b1};
                end
            end
        end
    end

    // Drain side outputs and the interrupt line
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data_valid <= 1'b0;
            tx_not_empty  <= 1'b0;
            irq           <= 1'b0;
        end else if (ce) begin
            tx_data_valid <= pop;
            tx_not_empty  <= ~flush & (tx_level != {(AW+1){1'b0}});
            irq           <= |masked;
        end
    end

    // Output copy of RAM data so the port stays on its own flip-flop
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data <= {DW{1'b0}};
        end else if (ce && tx_data_valid) begin
            tx_data <= mem_rdata;
        end
    end

    // Transmit FIFO storage
    isf_fifo_mem #(
        .DW (DW),
        .AW (AW)
    ) u_mem (
        .sys_clk (sys_clk),
        .ce      (ce),
        .wr_en   (push),
        .wr_addr (wr_ptr),
        .wr_data (pwdata[DW-1:0]),
        .rd_en   (pop),
        .rd_addr (rd_ptr),
        .rd_data (mem_rdata)
    );

endmodule // isf_status

// ---- bench/isf_checker.sv ----
`include "isf_defines.vh"

// Port-level watcher for the status flag block
module isf_checker (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        read_request_evt,
    input wire logic        abort_evt,
    input wire logic        fsm_active,
    input wire logic        tx_not_empty,
    input wire logic        scl_stretch,
    input wire logic        internal_enable_signal,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // Register access taken at this edge
    wire         tk = psel && penable && !pready && ce;
    wire         rd = tk && !pwrite;
    logic [11:0] mask_q;  // Shadow of the mask register
    logic        abrt_q;  // Abort seen and not yet cleared

    // Shadows follow the processor's writes and clear reads
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= 12'h08FF;
            abrt_q <= 1'b0;
        end else if (ce) begin
            if (tk && pwrite && paddr == `ISF_OFS_INTR_MASK)
                mask_q <= pwdata[11:0];
            // A new abort wins over a clear in the same cycle
            if (abort_evt)
                abrt_q <= 1'b1;
            else if (rd && paddr == `ISF_OFS_CLR_TX_ABRT)
                abrt_q <= 1'b0;
        end
    end

    property p_rdreq_set;
        ce && read_request_evt |=> scl_stretch;
    endproperty
    a_rdreq_set: assert property (p_rdreq_set) else $error("no stretch after request");
    property p_stretch_hold;
        ce && scl_stretch && internal_enable_signal
            && !(rd && (paddr == `ISF_OFS_CLR_RD_REQ || paddr == `ISF_OFS_CLR_INTR))
            |=> scl_stretch;
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) else $error("stretch dropped early");
    property p_rdreq_clear;
        rd && paddr == `ISF_OFS_CLR_RD_REQ && !read_request_evt |=> !scl_stretch;
    endproperty
    a_rdreq_clear: assert property (p_rdreq_clear) else $error("request not cleared");
    property p_irq_rdreq;
        $past(scl_stretch) && $past(mask_q[5]) && $past(ce) |-> irq;
    endproperty
    a_irq_rdreq: assert property (p_irq_rdreq) else $error("irq missing for request");
    property p_irq_masked;
        $past(mask_q) == 12'h0000 && $past(ce) |-> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with all masked");
    property p_flush;
        ce && abort_evt |=> ##1 !tx_not_empty;
    endproperty
    a_flush: assert property (p_flush) else $error("fifo not emptied on abort");
    property p_flush_hold;
        abrt_q && $past(abrt_q) |-> !tx_not_empty;
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("fifo filled during abort");
    property p_ien;
        ce && fsm_active |=> internal_enable_signal;
    endproperty
    a_ien: assert property (p_ien) else $error("enable fell while busy");
    property p_ready;
        tk |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("access answer malformed");

    c_rdreq: cover property ($rose(scl_stretch));
    c_abort: cover property (ce && abort_evt);
    c_slverr: cover property (pslverr);
endmodule // isf_checker

bind isf_status isf_checker u_chk (.*);

// ---- bench/isf_far_end.sv ----
// Controller core and remote bus parties as seen by the flag block
module isf_far_end (
    input  wire logic        sys_clk,
    input  wire logic        scl_stretch,
    input  wire logic        tx_data_valid,
    input  wire logic [8:0]  tx_data,
    output wire logic        start_restart_evt,
    output wire logic        stop_condition_evt,
    output wire logic        slave_tx_nack_evt,
    output wire logic        abort_evt,
    output wire logic        read_request_evt,
    output logic      [15:0] abort_cause = 16'h0000,
    output logic             core_active = 1'b0,
    output logic             fsm_active  = 1'b0,
    output logic             tx_pop      = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] evt = 5'h00;  // One-cycle event pulses
    logic [8:0] word;         // Last drained word
    logic       vld;          // Valid strobe seen for it
    assign {read_request_evt, abort_evt, slave_tx_nack_evt} = evt[4:2];
    assign {stop_condition_evt, start_restart_evt} = evt[1:0];

    // 0 start, 1 stop, 2 nack, 3 abort, 4 read request
    task automatic ev(input int i);
        @(posedge sys_clk);
        evt <= 5'h01 << i;
        @(posedge sys_clk);
        evt <= 5'h00;
    endtask

    // Cause travels with the abort pulse, then turns to junk
    task automatic abort(input logic [15:0] c);
        @(posedge sys_clk);
        abort_cause <= c;
        evt <= 5'h08;
        @(posedge sys_clk);
        evt <= 5'h00;
        abort_cause <= ~c;
    endtask

    // Controller busy for a few cycles
    task automatic act(input int n);
        @(posedge sys_clk);
        core_active <= 1'b1;
        repeat (n) @(posedge sys_clk);
        core_active <= 1'b0;
    endtask

    // State machines busy or idle
    task automatic fsm(input logic v);
        @(posedge sys_clk);
        fsm_active <= v;
        repeat (3) @(posedge sys_clk);
    endtask

    // Drain words; gap makes a slow remote reader
    task automatic pop(input int n, input int gap);
        repeat (n) begin
            // Remote master cannot clock while SCL is held
            for (int k = 0; k < 50 && scl_stretch; k++) @(posedge sys_clk);
            @(posedge sys_clk);
            tx_pop <= 1'b1;
            @(posedge sys_clk);
            tx_pop <= 1'b0;
            @(posedge sys_clk);
            vld = tx_data_valid;
            @(posedge sys_clk);
            word = tx_data;
            repeat (gap) @(posedge sys_clk);
        end
    endtask
endmodule // isf_far_end

// ---- bench/testbench.sv ----
`include "isf_defines.vh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        ce;              // Dropped once to check the freeze
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] rv;              // Last read data
    logic        err_q;           // Last error response
    wire  [31:0] prdata;
    wire  [15:0] abort_cause;
    wire  [8:0]  tx_data;
    wire         pready, pslverr, start_restart_evt, stop_condition_evt, core_active;
    wire         slave_tx_nack_evt, abort_evt, read_request_evt, fsm_active, tx_pop;
    wire         tx_data_valid, tx_not_empty, scl_stretch, internal_enable_signal, irq;
    int          n_errors = 0;
    int          n_checks = 0;

    always #12.5 sys_clk = ~sys_clk;

    isf_status DUT (.*);
    isf_far_end far (.*);

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Setup, access, hold until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 8);
        if (k >= 8)
            chk("pready", 32'h1, 32'h0);
        rv = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, e, rv);
    endtask

    task automatic raw(input logic [31:0] e);
        rd(`ISF_OFS_RAW_STAT, e, "raw status");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Watchdog, well past the test length
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        report_and_stop();
    end

    initial begin
        ce <= 1'b1;
        {psel, penable, pwrite, paddr, pwdata} <= 43'h000_0000_0000;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(`ISF_OFS_INTR_MASK, 32'h0000_08FF, "mask reset");
        rd(`ISF_OFS_INTR_STAT, 32'h0000_0000, "status reset");
        apb(1'b0, 8'hFC, 32'h0000_0000);
        chk("unmapped error", 32'h1, err_q);
        $display("test reset done");
        // Bus conditions and slave transmit completion
        apb(1'b1, `ISF_OFS_INTR_MASK, 32'h0000_0FFF);
        for (int i = 0; i < 3; i++) far.ev(i);
        raw(32'h0000_0680);
        rd(`ISF_OFS_INTR_STAT, 32'h0000_0680, "masked status");
        chk("irq", 32'h1, irq);
        apb(1'b0, `ISF_OFS_CLR_START, 32'h0000_0000);
        apb(1'b0, `ISF_OFS_CLR_STOP, 32'h0000_0000);
        apb(1'b0, `ISF_OFS_CLR_RX_DONE, 32'h0000_0000);
        raw(32'h0000_0000);
        $display("test events done");
        // Sticky activity and its clearing paths
        apb(1'b1, `ISF_OFS_ENABLE, 32'h0000_0001);
        far.act(3);
        raw(32'h0000_0110);
        apb(1'b0, `ISF_OFS_CLR_ACTIVITY, 32'h0000_0000);
        raw(32'h0000_0010);
        far.act(2);
        apb(1'b0, `ISF_OFS_CLR_INTR, 32'h0000_0000);
        raw(32'h0000_0010);
        far.act(2);
        apb(1'b1, `ISF_OFS_ENABLE, 32'h0000_0000);
        raw(32'h0000_0000);
        $display("test activity done");
        // Threshold tracking and FIFO order
        apb(1'b1, `ISF_OFS_ENABLE, 32'h0000_0001);
        apb(1'b1, `ISF_OFS_TX_TL, 32'h0000_0002);
        raw(32'h0000_0010);
        apb(1'b1, `ISF_OFS_DATA_CMD, 32'h0000_01A5);
        apb(1'b1, `ISF_OFS_DATA_CMD, 32'h0000_00C3);
        apb(1'b1, `ISF_OFS_DATA_CMD, 32'h0000_005A);
        raw(32'h0000_0000);
        rd(`ISF_OFS_TX_LEVEL, 32'h0000_0003, "level");
        far.pop(1, 0);
        chk("pop valid", 32'h1, far.vld);
        chk("first word", 32'h0000_01A5, far.word);
        raw(32'h0000_0010);
        far.pop(2, 3);
        chk("last word", 32'h0000_005A, far.word);
        $display("test level done");
        // Overflow, then disable while the state machines are busy
        for (int i = 0; i < 33; i++) apb(1'b1, `ISF_OFS_DATA_CMD, i);
        raw(32'h0000_0008);
        rd(`ISF_OFS_TX_LEVEL, 32'h0000_0020, "full level");
        far.fsm(1'b1);
        apb(1'b1, `ISF_OFS_ENABLE, 32'h0000_0000);
        raw(32'h0000_0018);
        far.fsm(1'b0);
        raw(32'h0000_0000);
        $display("test overflow done");
        // Transmit abort with queued data
        apb(1'b1, `ISF_OFS_ENABLE, 32'h0000_0001);
        apb(1'b1, `ISF_OFS_DATA_CMD, 32'h0000_0011);
        apb(1'b1, `ISF_OFS_DATA_CMD, 32'h0000_0022);
        far.abort(16'h0A5C);
        raw(32'h0000_0050);
        rd(`ISF_OFS_ABRT_CAUSE, 32'h0000_0A5C, "cause");
        rd(`ISF_OFS_TX_LEVEL, 32'h0000_0000, "flushed");
        apb(1'b1, `ISF_OFS_DATA_CMD, 32'h0000_0033);
        rd(`ISF_OFS_TX_LEVEL, 32'h0000_0000, "held flushed");
        apb(1'b0, `ISF_OFS_CLR_TX_ABRT, 32'h0000_0000);
        apb(1'b1, `ISF_OFS_DATA_CMD, 32'h0000_0044);
        rd(`ISF_OFS_TX_LEVEL, 32'h0000_0001, "accepts again");
        raw(32'h0000_0010);
        far.pop(1, 0);
        $display("test abort done");
        // Read request stretches SCL until serviced
        far.ev(4);
        @(negedge sys_clk);
        chk("stretch", 32'h1, scl_stretch);
        @(negedge sys_clk);
        chk("irq request", 32'h1, irq);
        raw(32'h0000_0030);
        chk("still stretched", 32'h1, scl_stretch);
        apb(1'b1, `ISF_OFS_DATA_CMD, 32'h0000_00AB);
        apb(1'b0, `ISF_OFS_CLR_RD_REQ, 32'h0000_0000);
        @(negedge sys_clk);
        chk("stretch released", 32'h0, scl_stretch);
        raw(32'h0000_0010);
        apb(1'b1, `ISF_OFS_INTR_MASK, 32'h0000_0000);
        repeat (2) @(negedge sys_clk);
        chk("irq masked", 32'h0, irq);
        far.pop(1, 0);
        chk("answer word", 32'h0000_00AB, far.word);
        // With the clock enable low a start pulse is lost
        ce <= 1'b0;
        far.ev(0);
        ce <= 1'b1;
        raw(32'h0000_0010);
        $display("test read request done");
        report_and_stop();
    end
endmodule // testbench
